// >>> panel_prog_pkg.sv
// Shared constants and types for the panel write sequencer
`default_nettype none
package panel_prog_pkg;

	// Array geometry
	localparam int NUM_PANELS     = 8;  // Code memory panels
	localparam int BUF_BYTES      = 8;  // Write buffer depth per panel
	localparam int PTR_BITS       = 22; // Table pointer width
	localparam int PANEL_LSB      = 13; // Pointer bit where panel select starts
	localparam int PANEL_SEL_BITS = 3;  // Panel select width
	localparam int OFFSET_LSB     = 3;  // Pointer bit where row offset starts
	localparam int OFFSET_BITS    = 10; // Row offset width within a panel
	localparam int BYTE_SEL_BITS  = 3;  // Byte select inside a buffer
	localparam int FRAME_BITS     = 20; // Command plus payload bits

	// Link framing
	localparam logic [4:0] FRAME_LAST    = 5'h13; // Index of last bit
	localparam logic [4:0] PROG_RISE_CNT = 5'h03; // Bits done at 4th rise

	// Four-bit commands
	localparam logic [3:0] CMD_CORE         = 4'h0; // Core instruction
	localparam logic [3:0] CMD_TWRITE       = 4'hc; // Table write
	localparam logic [3:0] CMD_TWRITE_INC   = 4'hd; // Write, pointer += 2
	localparam logic [3:0] CMD_TWRITE_START = 4'hf; // Write, start program

	// Core opcodes understood by the sequencer
	localparam logic [7:0] OP_MOVLW  = 8'h0e; // Literal into working reg
	localparam logic [7:0] OP_MOVWF  = 8'h6e; // Working reg into file reg
	localparam logic [7:0] OP_CLRF   = 8'h6a; // Clear file reg
	localparam logic [3:0] OP_BSF_HI = 4'h8;  // Bit set, upper nibble
	localparam logic [3:0] OP_BCF_HI = 4'h9;  // Bit clear, upper nibble

	// File register addresses
	localparam logic [7:0] REG_PTR_UPPER = 8'hf8; // Pointer upper byte
	localparam logic [7:0] REG_PTR_HIGH  = 8'hf7; // Pointer high byte
	localparam logic [7:0] REG_PTR_LOW   = 8'hf6; // Pointer low byte
	localparam logic [7:0] REG_MEM_CTRL  = 8'ha6; // Memory access control

	// Memory access control bit positions
	localparam int CODE_SEL_BIT     = 7; // Code space select
	localparam int CFG_SEL_BIT      = 6; // Config space select
	localparam int WRITE_PERMIT_BIT = 2; // Write permit

	// Panel write mode control register
	localparam logic [PTR_BITS-1:0] MODE_CTRL_ADDR = 22'h3c0006;
	localparam logic [7:0] MODE_MULTI      = 8'h40; // All panels at once
	localparam logic [7:0] MODE_SINGLE     = 8'h00; // Pointer panel only
	localparam logic [7:0] MODE_CTRL_RESET = 8'h00; // Value after reset
	localparam int         MODE_MULTI_BIT  = 6;     // Multi-panel enable bit

	localparam logic [PTR_BITS-1:0] PTR_INC = 22'h000002; // Post increment

	// Sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_ARMED,
		SEQ_PROGRAM
	} seq_state_t;

	// Write buffers of all panels
	typedef logic [NUM_PANELS-1:0][BUF_BYTES-1:0][7:0] panel_buf_t;

endpackage
`default_nettype wire

// >>> serial_link_if.sv
// Decoded serial link events between front end and sequencer
`timescale 1ns/100ps
`default_nettype none
interface serial_link_if;
	logic        clk_rise;    // Serial clock rose, one cycle
	logic        clk_fall;    // Serial clock fell, one cycle
	logic [4:0]  bit_cnt;     // Bits taken in current frame
	logic        frame_valid; // Whole frame taken, one cycle
	logic [3:0]  cmd;         // Command of last frame
	logic [15:0] payload;     // Payload of last frame

	modport front_end (
		output clk_rise,
		output clk_fall,
		output bit_cnt,
		output frame_valid,
		output cmd,
		output payload
	);
	modport sequencer (
		input clk_rise,
		input clk_fall,
		input bit_cnt,
		input frame_valid,
		input cmd,
		input payload
	);
endinterface
`default_nettype wire

// >>> serial_prog_front_end.sv
// Serial clock and data synchroniser and 20-bit frame shifter
`timescale 1ns/100ps
`default_nettype none
module serial_prog_front_end (
	input  wire logic            ref_clk_in,
	input  wire logic            resetn_in,
	input  wire logic            serial_prog_clock_in,
	input  wire logic            serial_prog_data_line_in,
	serial_link_if.front_end     lnk
);

	// All front end state
	typedef struct packed {
		logic        clk_s1;  // Clock sync stage one
		logic        clk_s2;  // Clock sync stage two
		logic        clk_old; // Clock delayed for edge find
		logic        dat_s1;  // Data sync stage one
		logic        dat_s2;  // Data sync stage two
		logic [19:0] shift;   // Bits, lsb first
		logic [4:0]  cnt;     // Bits taken so far
		logic        done;    // Frame complete pulse
		logic [19:0] frame;   // Last complete frame
	} fe_ff_t;

	fe_ff_t fe_ff;   // Registered state
	fe_ff_t nxt_fe;  // Next state
	logic   rise;    // Clock edge up
	logic   fall;    // Clock edge down

	// Edges come from the second stage only
	assign rise = fe_ff.clk_s2 & ~fe_ff.clk_old;
	assign fall = ~fe_ff.clk_s2 & fe_ff.clk_old;

	// Next state: sync, shift on falling edge, count to frame end
	always_comb begin
		nxt_fe         = fe_ff;
		nxt_fe.clk_s1  = serial_prog_clock_in;
		nxt_fe.clk_s2  = fe_ff.clk_s1;
		nxt_fe.clk_old = fe_ff.clk_s2;
		nxt_fe.dat_s1  = serial_prog_data_line_in;
		nxt_fe.dat_s2  = fe_ff.dat_s1;
		nxt_fe.done    = 1'b0;
		if (fall) begin
			// Data shifts in lsb first, so new bit goes on top
			nxt_fe.shift = {fe_ff.dat_s2, fe_ff.shift[19:1]};
			if (fe_ff.cnt == panel_prog_pkg::FRAME_LAST) begin
				nxt_fe.cnt   = 5'h00;
				nxt_fe.done  = 1'b1;
				nxt_fe.frame = {fe_ff.dat_s2, fe_ff.shift[19:1]};
			end else begin
				nxt_fe.cnt = fe_ff.cnt + 5'h01;
			end
		end
	end

	// State register, synchronous reset
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			fe_ff <= '0;
		end else begin
			fe_ff <= nxt_fe;
		end
	end

	assign lnk.clk_rise    = rise;
	assign lnk.clk_fall    = fall;
	assign lnk.bit_cnt     = fe_ff.cnt;
	assign lnk.frame_valid = fe_ff.done;
	assign lnk.cmd         = fe_ff.frame[3:0];
	assign lnk.payload     = fe_ff.frame[19:4];

endmodule
`default_nettype wire

// >>> code_memory_panel_programmer.sv
// Code memory panel write sequencer behind the serial programming pins
//
// Notes on behaviour
// - Each panel owns an eight-byte write buffer
// - Multi-panel mode programs all buffers, same offset
// - Mode register at 3C0006h selects write mode
// - Table write 40h there enables multi-panel
// - Program while fourth NOP clock stays high
// - Falling serial clock ends the programming cycle
// - Command 1101 stores two bytes, pointer +2
// - Command 1111 stores bytes, starts programming
// - Single-panel mode enables only pointer's panel
// - Table write 00h selects single-panel mode
`timescale 1ns/100ps
`default_nettype none
module code_memory_panel_programmer (
	input  wire logic                   ref_clk_in,
	input  wire logic                   resetn_in,
	input  wire logic                   serial_prog_clock_in,
	input  wire logic                   serial_prog_data_line_in,
	output logic                        program_active_out,
	output logic [7:0]                  panel_enable_out,
	output logic [9:0]                  panel_offset_out,
	output panel_prog_pkg::panel_buf_t  buffer_data_out,
	output logic [7:0]                  mode_ctrl_out,
	output logic [21:0]                 table_address_pointer_out,
	output logic [7:0]                  memory_access_control_out
);

	// All sequencer state
	typedef struct packed {
		panel_prog_pkg::seq_state_t state;     // Cycle phase
		logic [21:0]                ptr;       // Table pointer
		logic [7:0]                 wreg;      // Working register
		logic [7:0]                 mem_ctrl;  // Memory access control
		logic [7:0]                 mode_ctrl; // Panel write mode
		panel_prog_pkg::panel_buf_t bufs;      // Panel write buffers
		logic [7:0]                 panel_en;  // Panels being programmed
		logic [9:0]                 offset;    // Row offset in each panel
	} seq_ff_t;

	seq_ff_t     seq_ff;     // Registered state
	seq_ff_t     nxt_seq;    // Next state
	logic [7:0]  panel_hit;  // One-hot panel of current pointer
	logic [2:0]  wr_panel;   // Panel addressed by pointer
	logic [2:0]  wr_byte;    // Even byte addressed by pointer
	logic        wr_cmd;     // Frame is one of the table writes
	logic        accept;     // Frame may be acted on
	logic        wr_code;    // Table write lands in a buffer
	logic        wr_mode;    // Table write lands in mode register
	logic [7:0]  op;         // Core opcode byte
	logic [7:0]  arg;        // Core operand byte
	logic [7:0]  mv_val;     // Value moved into a file register

	serial_link_if lnk ();

	// Pin synchroniser and frame shifter
	serial_prog_front_end front (
		.ref_clk_in               (ref_clk_in),
		.resetn_in                (resetn_in),
		.serial_prog_clock_in     (serial_prog_clock_in),
		.serial_prog_data_line_in (serial_prog_data_line_in),
		.lnk                      (lnk.front_end)
	);

	// One comparator per panel for the pointer's panel
	genvar g;
	generate
		for (g = 0; g < panel_prog_pkg::NUM_PANELS; g++) begin : g_hit
			assign panel_hit[g] = (wr_panel == 3'(g));
		end
	endgenerate

	// Address and command decode
	assign wr_panel = seq_ff.ptr[panel_prog_pkg::PANEL_LSB +:
		panel_prog_pkg::PANEL_SEL_BITS];
	assign wr_byte  = {seq_ff.ptr[2:1], 1'b0};
	assign accept   = lnk.frame_valid &&
		(seq_ff.state == panel_prog_pkg::SEQ_IDLE);
	assign wr_cmd   = (lnk.cmd == panel_prog_pkg::CMD_TWRITE) ||
		(lnk.cmd == panel_prog_pkg::CMD_TWRITE_INC) ||
		(lnk.cmd == panel_prog_pkg::CMD_TWRITE_START);
	// Config space wins over code space when both are set
	assign wr_mode  = accept && wr_cmd &&
		seq_ff.mem_ctrl[panel_prog_pkg::CFG_SEL_BIT] &&
		(seq_ff.ptr == panel_prog_pkg::MODE_CTRL_ADDR);
	assign wr_code  = accept && wr_cmd &&
		seq_ff.mem_ctrl[panel_prog_pkg::CODE_SEL_BIT] &&
		!seq_ff.mem_ctrl[panel_prog_pkg::CFG_SEL_BIT];
	assign op       = lnk.payload[15:8];
	assign arg      = lnk.payload[7:0];
	assign mv_val   = (op == panel_prog_pkg::OP_MOVWF) ? seq_ff.wreg : 8'h00;

	// Next state: frame decode, buffer loading, programming phases
	always_comb begin
		nxt_seq = seq_ff;
		// Core instructions only touch pointer, W and access control
		if (accept && (lnk.cmd == panel_prog_pkg::CMD_CORE)) begin
			if (op == panel_prog_pkg::OP_MOVLW) begin
				nxt_seq.wreg = arg;
			end else if ((op == panel_prog_pkg::OP_MOVWF) ||
				(op == panel_prog_pkg::OP_CLRF)) begin
				case (arg)
					panel_prog_pkg::REG_PTR_UPPER: begin
						nxt_seq.ptr[21:16] = mv_val[5:0];
					end
					panel_prog_pkg::REG_PTR_HIGH: begin
						nxt_seq.ptr[15:8] = mv_val;
					end
					panel_prog_pkg::REG_PTR_LOW: begin
						nxt_seq.ptr[7:0] = mv_val;
					end
					panel_prog_pkg::REG_MEM_CTRL: begin
						nxt_seq.mem_ctrl = mv_val;
					end
					default: begin
						nxt_seq.wreg = seq_ff.wreg;
					end
				endcase
			end else if (arg == panel_prog_pkg::REG_MEM_CTRL) begin
				// Bit set or clear on access control, bit in op[3:1]
				if (op[7:4] == panel_prog_pkg::OP_BSF_HI) begin
					nxt_seq.mem_ctrl[op[3:1]] = 1'b1;
				end else if (op[7:4] == panel_prog_pkg::OP_BCF_HI) begin
					nxt_seq.mem_ctrl[op[3:1]] = 1'b0;
				end
			end
		end
		// Mode register takes the low payload byte
		if (wr_mode) begin
			nxt_seq.mode_ctrl = arg;
		end
		// Buffer write: low byte at even address, high byte next
		if (wr_code) begin
			nxt_seq.bufs[wr_panel][wr_byte]        = arg;
			nxt_seq.bufs[wr_panel][wr_byte | 3'h1] = op;
		end
		// Post increment applies in either space
		if (accept && (lnk.cmd == panel_prog_pkg::CMD_TWRITE_INC)) begin
			nxt_seq.ptr = seq_ff.ptr + panel_prog_pkg::PTR_INC;
		end
		// Phase sequencing
		case (seq_ff.state)
			panel_prog_pkg::SEQ_IDLE: begin
				if (accept &&
					(lnk.cmd == panel_prog_pkg::CMD_TWRITE_START)) begin
					nxt_seq.state  = panel_prog_pkg::SEQ_ARMED;
					// Offset taken from pointer that loaded the buffers
					nxt_seq.offset = seq_ff.ptr[panel_prog_pkg::OFFSET_LSB
						+: panel_prog_pkg::OFFSET_BITS];
					if (seq_ff.mode_ctrl[panel_prog_pkg::MODE_MULTI_BIT]) begin
						nxt_seq.panel_en = '1;
					end else begin
						nxt_seq.panel_en = panel_hit;
					end
				end
			end
			panel_prog_pkg::SEQ_ARMED: begin
				// Fourth clock of the following NOP opens the pulse
				if (lnk.clk_rise &&
					(lnk.bit_cnt == panel_prog_pkg::PROG_RISE_CNT)) begin
					nxt_seq.state = panel_prog_pkg::SEQ_PROGRAM;
				end
			end
			panel_prog_pkg::SEQ_PROGRAM: begin
				// Pulse width is the programmer's; discharge too
				if (lnk.clk_fall) begin
					nxt_seq.state    = panel_prog_pkg::SEQ_IDLE;
					nxt_seq.panel_en = 8'h00;
				end
			end
			default: begin
				nxt_seq.state = panel_prog_pkg::SEQ_IDLE;
			end
		endcase
	end

	// State register, synchronous reset
	always_ff @(posedge ref_clk_in) begin
		if (!resetn_in) begin
			seq_ff           <= '0;
			seq_ff.state     <= panel_prog_pkg::SEQ_IDLE;
			seq_ff.mode_ctrl <= panel_prog_pkg::MODE_CTRL_RESET;
		end else begin
			seq_ff <= nxt_seq;
		end
	end

	// Outputs straight from flops, except pulse flag decoded from state
	assign program_active_out        =
		(seq_ff.state == panel_prog_pkg::SEQ_PROGRAM);
	assign panel_enable_out          = seq_ff.panel_en;
	assign panel_offset_out          = seq_ff.offset;
	assign buffer_data_out           = seq_ff.bufs;
	assign mode_ctrl_out             = seq_ff.mode_ctrl;
	assign table_address_pointer_out = seq_ff.ptr;
	assign memory_access_control_out = seq_ff.mem_ctrl;

	// Pulse opens on the fourth rise after arming
	a_pulse_opens: assert property (
		@(posedge ref_clk_in) disable iff (!resetn_in)
		(seq_ff.state == panel_prog_pkg::SEQ_ARMED) && lnk.clk_rise &&
		(lnk.bit_cnt == panel_prog_pkg::PROG_RISE_CNT)
		|=> program_active_out)
		else $error("programming pulse did not start");

	// Pulse holds until the clock falls
	a_pulse_holds: assert property (
		@(posedge ref_clk_in) disable iff (!resetn_in)
		program_active_out && !lnk.clk_fall |=> program_active_out)
		else $error("programming pulse dropped early");

	// Falling clock ends the pulse and clears enables
	a_pulse_ends: assert property (
		@(posedge ref_clk_in) disable iff (!resetn_in)
		program_active_out && lnk.clk_fall
		|=> !program_active_out && (panel_enable_out == 8'h00))
		else $error("programming pulse did not end");

	// Start arms the sequencer
	a_start_arms: assert property (
		@(posedge ref_clk_in) disable iff (!resetn_in)
		accept && (lnk.cmd == panel_prog_pkg::CMD_TWRITE_START)
		|=> (seq_ff.state == panel_prog_pkg::SEQ_ARMED) && !program_active_out)
		else $error("start command did not arm");

	// Multi-panel start enables every panel at pointer offset
	a_multi_enables: assert property (
		@(posedge ref_clk_in) disable iff (!resetn_in)
		accept && (lnk.cmd == panel_prog_pkg::CMD_TWRITE_START) &&
		mode_ctrl_out[panel_prog_pkg::MODE_MULTI_BIT]
		|=> (panel_enable_out == 8'hff) &&
		(panel_offset_out == $past(table_address_pointer_out[12:3])))
		else $error("multi-panel enables wrong");

	// Single-panel start enables only the pointer's panel
	a_single_enable: assert property (
		@(posedge ref_clk_in) disable iff (!resetn_in)
		accept && (lnk.cmd == panel_prog_pkg::CMD_TWRITE_START) &&
		!mode_ctrl_out[panel_prog_pkg::MODE_MULTI_BIT]
		|=> $onehot(panel_enable_out) &&
		panel_enable_out[$past(wr_panel)])
		else $error("single-panel enable wrong");

	// Increment write advances pointer by two
	a_ptr_plus_two: assert property (
		@(posedge ref_clk_in) disable iff (!resetn_in)
		accept && (lnk.cmd == panel_prog_pkg::CMD_TWRITE_INC)
		|=> table_address_pointer_out ==
		22'($past(table_address_pointer_out) + 22'h000002))
		else $error("pointer did not advance by two");

	// Mode register write takes the low byte
	a_mode_write: assert property (
		@(posedge ref_clk_in) disable iff (!resetn_in)
		wr_mode |=> mode_ctrl_out == $past(lnk.payload[7:0]))
		else $error("mode register not written");

	// Buffer write stores both bytes at pointer
	a_buf_store: assert property (
		@(posedge ref_clk_in) disable iff (!resetn_in)
		wr_code |=>
		(buffer_data_out[$past(wr_panel)][$past(wr_byte)] ==
		$past(lnk.payload[7:0])) &&
		(buffer_data_out[$past(wr_panel)][$past(wr_byte) | 3'h1] ==
		$past(lnk.payload[15:8])))
		else $error("buffer bytes not stored");

endmodule
`default_nettype wire

// >>> prog_link_model.sv
// Behavioural external programmer driving serial clock and data
`timescale 1ns/100ps
`default_nettype none
module prog_link_model (
	output logic serial_prog_clock_out,
	output logic serial_prog_data_line_out
);
	// Clock idles low outside frames, never runs free
	initial begin
		serial_prog_clock_out     = 1'b0;
		serial_prog_data_line_out = 1'b0;
	end

	// One bit of a 48 ns period; data moves only while clock is low
	task automatic bit_out(input logic b);
		serial_prog_data_line_out = b;
		#12 serial_prog_clock_out = 1'b1;
		#24 serial_prog_clock_out = 1'b0;
		#12;
	endtask

	// Whole frame: command then payload, both LSB first
	task automatic frame(input logic [3:0] cmd, input logic [15:0] pl);
		for (int i = 0; i < 4; i++) bit_out(cmd[i]);
		for (int i = 0; i < 16; i++) bit_out(pl[i]);
		// Stale data is not held; show its inverse between frames
		serial_prog_data_line_out = ~pl[15];
		// Gap lets the block finish acting on the frame
		#60;
	endtask

	// Pointer set as upper, high, low bytes through core moves
	task automatic set_ptr(input logic [21:0] a);
		frame(4'h0, {8'h0e, 2'b00, a[21:16]});
		frame(4'h0, 16'h6ef8);
		frame(4'h0, {8'h0e, a[15:8]});
		frame(4'h0, 16'h6ef7);
		frame(4'h0, {8'h0e, a[7:0]});
		frame(4'h0, 16'h6ef6);
	endtask

	// Full eight-byte buffer, offset untouched until start
	task automatic load_panel(input logic [21:0] base, input logic [63:0] d,
			input logic last);
		set_ptr(base);
		for (int k = 0; k < 3; k++) frame(4'hd, d[16*k+:16]);
		// Only the last panel starts the cycle
		frame(last ? 4'hf : 4'hc, d[48+:16]);
	endtask

	// NOP up to its fourth rise, clock then left high
	task automatic nop_rise();
		for (int i = 0; i < 3; i++) bit_out(1'b0);
		serial_prog_data_line_out = 1'b0;
		#12 serial_prog_clock_out = 1'b1;
	endtask

	// Fall ends the pulse, low hold covers discharge, rest of NOP follows
	task automatic nop_fall(input int discharge_ns);
		serial_prog_clock_out = 1'b0;
		#(discharge_ns);
		#12;
		for (int i = 0; i < 16; i++) bit_out(1'b0);
		serial_prog_data_line_out = 1'b1;
		#60;
	endtask
endmodule
`default_nettype wire

// >>> code_memory_panel_programmer_tb.sv
// Self-checking bench for the code memory panel write sequencer
`timescale 1ns/100ps
`default_nettype none
module code_memory_panel_programmer_tb;
	logic                       ref_clk_in;                // System clock
	logic                       resetn_in;                 // Active low
	wire logic                  sclk;                      // Serial clock
	wire logic                  sdat;                      // Serial data
	logic                       program_active_out;        // Pulse active
	logic [7:0]                 panel_enable_out;          // Panels on
	logic [9:0]                 panel_offset_out;          // Row offset
	panel_prog_pkg::panel_buf_t buffer_data_out;           // Buffers
	logic [7:0]                 mode_ctrl_out;             // Mode register
	logic [21:0]                table_address_pointer_out; // Pointer
	logic [7:0]                 memory_access_control_out; // Access ctrl
	int                         failures;                  // Mismatches
	int                         n_checks;                  // Comparisons

	// Far-side programmer
	prog_link_model prog (
		.serial_prog_clock_out     (sclk),
		.serial_prog_data_line_out (sdat)
	);

	code_memory_panel_programmer DUT (
		.ref_clk_in                (ref_clk_in),
		.resetn_in                 (resetn_in),
		.serial_prog_clock_in      (sclk),
		.serial_prog_data_line_in  (sdat),
		.program_active_out        (program_active_out),
		.panel_enable_out          (panel_enable_out),
		.panel_offset_out          (panel_offset_out),
		.buffer_data_out           (buffer_data_out),
		.mode_ctrl_out             (mode_ctrl_out),
		.table_address_pointer_out (table_address_pointer_out),
		.memory_access_control_out (memory_access_control_out)
	);

	// 200 MHz clock
	initial begin
		ref_clk_in = 1'b0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end

	// Verdict and end of run
	task automatic end_sim();
		$display("Checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Value compare; zero extension keeps unknowns visible
	task automatic chk(input logic [63:0] got, input logic [63:0] exp,
			input string what);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: %s got %0h expected %0h", $time, what,
				got, exp);
		end
	endtask

	// Buffer contents per panel, varied by panel and byte index
	function automatic logic [63:0] fill(input int p, input logic [7:0] x);
		logic [63:0] d;
		for (int b = 0; b < 8; b++) d[8*b+:8] = {p[2:0], b[2:0], 2'b10} ^ x;
		return d;
	endfunction

	// Bounded wait for the pulse flag
	task automatic wait_active(input logic v);
		for (int i = 0; i < 40 && program_active_out !== v; i++) begin
			@(negedge ref_clk_in);
		end
		chk(program_active_out, v, "pulse flag");
	endtask

	// Mode write through config space, then back to code space
	task automatic mode_write(input logic [7:0] v);
		prog.frame(4'h0, 16'h8ea6);
		prog.frame(4'h0, 16'h8ca6);
		// Write permit is bit two, so the bit field of the set is 3'h2
		prog.frame(4'h0, 16'h84a6);
		chk(memory_access_control_out, 8'hc4, "cfg access");
		prog.set_ptr(22'h3c0006);
		prog.frame(4'hc, {8'h00, v});
		chk(mode_ctrl_out, v, "mode reg");
		chk(table_address_pointer_out, 22'h3c0006, "no inc");
		prog.frame(4'h0, 16'h8ea6);
		prog.frame(4'h0, 16'h9ca6);
		chk(memory_access_control_out, 8'h84, "code access");
	endtask

	// Start pulse held by the programmer, then released
	task automatic pulse(input logic [21:0] ptr);
		prog.nop_rise();
		wait_active(1'b1);
		// Hold length is the programmer's own choice
		repeat (40) @(negedge ref_clk_in);
		chk(program_active_out, 1'b1, "held high");
		prog.nop_fall(200);
		chk(program_active_out, 1'b0, "pulse end");
		chk(panel_enable_out, 8'h00, "panels off");
		chk(table_address_pointer_out, ptr, "nop ignored");
	endtask

	// Outputs after reset
	task automatic t_reset();
		chk(mode_ctrl_out, 8'h00, "mode reset");
		chk(program_active_out, 1'b0, "idle");
		chk(panel_enable_out, 8'h00, "no panels");
		chk(table_address_pointer_out, 22'h0, "ptr reset");
	endtask

	// All eight panels committed at one offset
	task automatic t_multi();
		logic [21:0] base;
		logic [63:0] d;
		mode_write(8'h40);
		for (int p = 0; p < 8; p++) begin
			base = {6'h00, p[2:0], 10'h155, 3'b000};
			prog.load_panel(base, fill(p, 8'h00), p == 7);
			// Three increments of two, final write holds pointer
			chk(table_address_pointer_out, base + 22'h6, "ptr");
		end
		chk(panel_enable_out, 8'hff, "all panels");
		chk(panel_offset_out, 10'h155, "offset");
		for (int p = 0; p < 8; p++) begin
			d = fill(p, 8'h00);
			for (int b = 0; b < 8; b++) begin
				chk(buffer_data_out[p][b], d[8*b+:8], "buf");
			end
		end
		pulse(base + 22'h6);
	endtask

	// One panel chosen by the pointer
	task automatic t_single();
		logic [21:0] base;
		logic [63:0] d;
		mode_write(8'h00);
		base = {6'h00, 3'h5, 10'h02a, 3'b000};
		d = fill(5, 8'hff);
		prog.load_panel(base, d, 1'b1);
		chk(panel_enable_out, 8'h20, "one panel");
		chk(panel_offset_out, 10'h02a, "offset");
		for (int b = 0; b < 8; b++) begin
			chk(buffer_data_out[5][b], d[8*b+:8], "buf");
		end
		// Other panels keep earlier contents
		d = fill(4, 8'h00);
		chk(buffer_data_out[4][0], d[7:0], "untouched");
		pulse(base + 22'h6);
		// Clear of the low pointer byte leaves panel and high bits
		prog.frame(4'h0, 16'h6af6);
		chk(table_address_pointer_out, 22'h00a100, "clear low");
	endtask

	// Main sequence; reset driven on falling edges
	initial begin
		failures = 0;
		n_checks = 0;
		resetn_in = 1'b0;
		repeat (8) @(negedge ref_clk_in);
		resetn_in = 1'b1;
		repeat (4) @(negedge ref_clk_in);
		t_reset();
		t_multi();
		t_single();
		end_sim();
	end

	// Hang guard, about 80k cycles
	initial begin
		#400000;
		failures++;
		$display("Error at %0t: run timed out", $time);
		end_sim();
	end
endmodule
`default_nettype wire
